//--- src/mrp_pkg.sv
package mrp_pkg;

   // Timing
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned OSC_STAB_NS = 1000000;
   localparam int unsigned OSC_STAB_CYC = (OSC_STAB_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] PHASE_LAST = 4'hB;
   localparam logic [3:0] STATE5_PHASE2 = 4'h9;
   localparam logic [2:0] ALE_LAST = 3'h5;
   localparam logic [2:0] ALE_HIGH = 3'h2;
   localparam logic [1:0] RST_MIN_SAMPLES = 2'h2;

   // Register offsets
   localparam logic [7:0] ADDR_PORT0 = 8'h80;
   localparam logic [7:0] ADDR_STACK_PTR = 8'h81;
   localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
   localparam logic [7:0] ADDR_PORT1 = 8'h90;
   localparam logic [7:0] ADDR_SERIAL_BUF = 8'h99;
   localparam logic [7:0] ADDR_PORT2 = 8'hA0;
   localparam logic [7:0] ADDR_WAKE_EN = 8'hA8;
   localparam logic [7:0] ADDR_PORT3 = 8'hB0;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'hE1;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hE2;

   // Reset values
   localparam logic [7:0] PORT_RST = 8'hFF;
   localparam logic [7:0] STACK_PTR_RST = 8'h07;
   localparam logic [7:0] SFR_RST = 8'h00;
   localparam logic [7:0] POWER_CTRL_POR = 8'h10;

   // Field positions
   localparam int unsigned POF_BIT = 4;
   localparam int unsigned RSVD_BIT = 5;
   localparam int unsigned PD_BIT = 1;
   localparam int unsigned IDL_BIT = 0;
   localparam int unsigned WAKE_EN0_BIT = 0;
   localparam int unsigned WAKE_EN1_BIT = 2;
   localparam int unsigned EV_IDLE = 0;
   localparam int unsigned EV_PDOWN = 1;
   localparam int unsigned EV_WAKE = 2;
   localparam int unsigned EV_RESET = 3;
   localparam int unsigned EV_COUNT = 4;

   typedef enum logic [1:0] {
      PM_RUN = 2'b00,
      PM_PDOWN = 2'b01,
      PM_WARM = 2'b11,
      PM_IDLE = 2'b10
   } mrp_pmode_e;

   typedef struct packed {
      logic [7:0] p3;
      logic [7:0] p2;
      logic [7:0] p1;
      logic [7:0] p0;
   } mrp_ports_s;

   typedef struct packed {
      logic cpuClkEn;
      logic periphClkEn;
      logic oscEn;
   } mrp_clk_s;

endpackage

//--- src/mrp_reset_power.sv
// Operation
// (R1) Reset pin held two machine cycles
// (R2) Reset pin sampled at state5_phase2
// (R3) Short reset pulses are filtered out
// (R4) Reset loads all port latches with ones
// (R5) Reset loads stack pointer with seven
// (R6) Reset clears other special registers; the code does not clear interrupt status and mask on it
// (R7) Reset leaves serial buffer unchanged
// (R8) Reset keeps power-on flag bit
// (R9) Power-on sets flag, software clears
// (R10) Idle request gates core clock
// (R11) Idle keeps peripheral clock running
// (R12) Interrupt or reset ends idle
// (R13) Power-down stops clocks and oscillator
// (R14) Power-down ends on reset or interrupt
// (R15) Bit1 power-down, bit0 idle request
// (R16) Address strobe at one sixth rate
// (R17) Option bit7 zero below 25 MHz
// (R18) Low-power modes entered only by software
// (R19) Wake waits for oscillator, then services
`timescale 1ns/10ps
module mrp_reset_power
   import mrp_pkg::*;
#(
   parameter int unsigned STAB_CYC = OSC_STAB_CYC
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic extResetPin,
   input wire logic extIrqZero,
   input wire logic extIrqOne,
   input wire logic irqPending,
   input wire logic extAccess,
   input wire logic optEmiLow,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   output mrp_ports_s portLatch,
   output mrp_clk_s clocks,
   output logic coreReset,
   output logic aleOut,
   output logic wakeService,
   output logic irqOut
);

   mrp_pmode_e mode_q;
   mrp_pmode_e mode_d;
   logic [3:0] phase_q;
   logic [2:0] aleCnt_q;
   logic aleOut_q;
   logic [1:0] rstCnt_q;
   logic coreReset_q;
   logic [7:0] port_q [4];
   logic [7:0] stackPtr_q;
   logic [7:0] powerCtrl_q;
   logic [7:0] serialBuf_q;
   logic [7:0] wakeEn_q;
   logic [EV_COUNT-1:0] irqStat_q;
   logic [EV_COUNT-1:0] irqMask_q;
   logic [EV_COUNT-1:0] events;
   logic [7:0] rdData_q;
   logic [31:0] stabCnt_q;
   logic wakeByIrq_q;
   logic wakeService_q;
   logic oscRun;
   logic extWake;
   logic stabDone;
   logic exitIdle;
   logic exitPdown;
   logic aleAllow;

   function automatic logic wrHit(input logic [7:0] offset);
      wrHit = regWr && (regAddr == offset);
   endfunction

   assign oscRun = (mode_q != PM_PDOWN);
   // Wake sources
   assign extWake = (extIrqZero && wakeEn_q[WAKE_EN0_BIT]) ||
                    (extIrqOne && wakeEn_q[WAKE_EN1_BIT]);
   assign stabDone = (stabCnt_q == STAB_CYC - 1);
   assign exitIdle = (mode_q == PM_IDLE) && (irqPending || coreReset_q);
   assign exitPdown = (mode_q == PM_WARM) && stabDone;
   // (R17) Strobe inhibit option
   assign aleAllow = optEmiLow || extAccess;

   // Machine cycle phase counter
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         phase_q <= 4'h0;
      else if (clkEn && oscRun)
         phase_q <= (phase_q == PHASE_LAST) ? 4'h0 : phase_q + 4'h1;
   end

   // Address strobe generation
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aleCnt_q <= 3'h0;
         aleOut_q <= 1'b0;
      end
      else if (clkEn)
      begin
         // (R16) One sixth rate
         aleCnt_q <= (!oscRun || aleCnt_q == ALE_LAST) ? 3'h0 : aleCnt_q + 3'h1;
         aleOut_q <= oscRun && aleAllow && (aleCnt_q < ALE_HIGH);
      end
   end

   // Reset pin filter
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstCnt_q <= 2'h0;
         coreReset_q <= 1'b0;
      end
      // (R2) Sample at state5_phase2
      else if (clkEn && oscRun && phase_q == STATE5_PHASE2)
      begin
         // (R1) (R3) Two consecutive samples
         if (!extResetPin)
         begin
            rstCnt_q <= 2'h0;
            coreReset_q <= 1'b0;
         end
         else if (rstCnt_q != RST_MIN_SAMPLES)
         begin
            rstCnt_q <= rstCnt_q + 2'h1;
            coreReset_q <= (rstCnt_q + 2'h1 == RST_MIN_SAMPLES);
         end
      end
   end

   // Power mode state machine
   always_comb
   begin
      mode_d = mode_q;
      case (mode_q)
         PM_RUN:
            // (R18) (R15) Software bits only
            if (!coreReset_q && powerCtrl_q[PD_BIT])
               mode_d = PM_PDOWN;
            else if (!coreReset_q && powerCtrl_q[IDL_BIT])
               mode_d = PM_IDLE;
         PM_IDLE:
            // (R12) Interrupt or reset exit
            if (exitIdle)
               mode_d = PM_RUN;
         PM_PDOWN:
            // (R14) Reset or enabled interrupt
            if (extWake || extResetPin)
               mode_d = PM_WARM;
         PM_WARM:
            // (R19) Oscillator settle time
            if (stabDone)
               mode_d = PM_RUN;
         default:
            mode_d = PM_RUN;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         mode_q <= PM_RUN;
      else if (clkEn)
         mode_q <= mode_d;
   end

   // Oscillator stabilisation and wake service
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stabCnt_q <= 32'h0;
         wakeByIrq_q <= 1'b0;
         wakeService_q <= 1'b0;
      end
      else if (clkEn)
      begin
         stabCnt_q <= (mode_q == PM_WARM && !stabDone) ? stabCnt_q + 32'h1 : 32'h0;
         if (mode_q == PM_PDOWN)
            wakeByIrq_q <= extWake && !extResetPin;
         // (R19) Service after settle
         wakeService_q <= exitPdown && wakeByIrq_q;
      end
   end

   // (R10) (R11) (R13) Clock gating
   assign clocks.cpuClkEn = (mode_q == PM_RUN);
   assign clocks.periphClkEn = (mode_q == PM_RUN) || (mode_q == PM_IDLE);
   assign clocks.oscEn = oscRun;

   // Port latches
   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_port
         always_ff @(posedge mclk or negedge rst_n)
         begin
            if (!rst_n)
               port_q[i] <= PORT_RST;
            else if (clkEn)
            begin
               // (R4) Ports to ones
               if (coreReset_q)
                  port_q[i] <= PORT_RST;
               else if (wrHit(ADDR_PORT0 + 8'(i * 16)))
                  port_q[i] <= regWdata;
            end
         end
      end
   endgenerate

   // Stack pointer and wake enables
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stackPtr_q <= STACK_PTR_RST;
         wakeEn_q <= SFR_RST;
      end
      else if (clkEn)
      begin
         // (R5) (R6) Reset values
         if (coreReset_q)
         begin
            stackPtr_q <= STACK_PTR_RST;
            wakeEn_q <= SFR_RST;
         end
         else
         begin
            if (wrHit(ADDR_STACK_PTR))
               stackPtr_q <= regWdata;
            if (wrHit(ADDR_WAKE_EN))
               wakeEn_q <= regWdata;
         end
      end
   end

   // (R7) Serial buffer has no reset
   always_ff @(posedge mclk)
   begin
      if (clkEn && !coreReset_q && wrHit(ADDR_SERIAL_BUF))
         serialBuf_q <= regWdata;
   end

   // Power control register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      // (R9) Power-on sets flag
      if (!rst_n)
         powerCtrl_q <= POWER_CTRL_POR;
      else if (clkEn)
      begin
         // (R8) (R6) Keep flag, clear rest
         if (coreReset_q)
            powerCtrl_q <= SFR_RST | (powerCtrl_q & (8'h1 << POF_BIT));
         else if (wrHit(ADDR_POWER_CTRL))
            powerCtrl_q <= regWdata & ~(8'h1 << RSVD_BIT);
         else
         begin
            if (exitIdle)
               powerCtrl_q[IDL_BIT] <= 1'b0;
            if (exitPdown)
               powerCtrl_q[PD_BIT] <= 1'b0;
         end
      end
   end

   // Interrupt status, mask and read data
   assign events[EV_IDLE] = (mode_q == PM_RUN) && (mode_d == PM_IDLE);
   assign events[EV_PDOWN] = (mode_q == PM_RUN) && (mode_d == PM_PDOWN);
   assign events[EV_WAKE] = exitPdown;
   assign events[EV_RESET] = (phase_q == STATE5_PHASE2) && oscRun && extResetPin &&
                             (rstCnt_q + 2'h1 == RST_MIN_SAMPLES);

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irqStat_q <= '0;
         irqMask_q <= '0;
         rdData_q <= 8'h00;
      end
      else if (clkEn)
      begin
         irqStat_q <= ((regRd && regAddr == ADDR_IRQ_STAT) ? '0 : irqStat_q) | events;
         if (wrHit(ADDR_IRQ_MASK))
            irqMask_q <= regWdata[EV_COUNT-1:0];
         rdData_q <= 8'h00;
         if (regRd)
            case (regAddr)
               ADDR_PORT0: rdData_q <= port_q[0];
               ADDR_PORT1: rdData_q <= port_q[1];
               ADDR_PORT2: rdData_q <= port_q[2];
               ADDR_PORT3: rdData_q <= port_q[3];
               ADDR_STACK_PTR: rdData_q <= stackPtr_q;
               ADDR_POWER_CTRL: rdData_q <= powerCtrl_q;
               ADDR_SERIAL_BUF: rdData_q <= serialBuf_q;
               ADDR_WAKE_EN: rdData_q <= wakeEn_q;
               ADDR_IRQ_STAT: rdData_q <= {4'h0, irqStat_q};
               ADDR_IRQ_MASK: rdData_q <= {4'h0, irqMask_q};
               default: rdData_q <= 8'h00;
            endcase
      end
   end

   assign regRdata = rdData_q;
   assign portLatch = '{p3: port_q[3], p2: port_q[2], p1: port_q[1], p0: port_q[0]};
   assign coreReset = coreReset_q;
   assign aleOut = aleOut_q;
   assign wakeService = wakeService_q;
   assign irqOut = |(irqStat_q & irqMask_q);

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n || !clkEn);

   chk_rst_sample: assert property ($rose(coreReset_q) |-> $past(phase_q) == STATE5_PHASE2) // (R2)
      else $error("Reset accepted off the sampling phase");
   chk_rst_glitch: assert property ($rose(coreReset_q) |-> $past(rstCnt_q) == 2'h1) // (R3)
      else $error("Reset accepted after a single sample");
   chk_port_ones: assert property (coreReset_q |=> portLatch == {4{PORT_RST}}) // (R4)
      else $error("Ports not all ones during reset");
   chk_stack_seven: assert property (coreReset_q |=> stackPtr_q == STACK_PTR_RST) // (R5)
      else $error("Stack pointer not seven during reset");
   chk_sfr_clear: assert property (coreReset_q |=> wakeEn_q == SFR_RST && // (R6)
      powerCtrl_q[3:0] == 4'h0)
      else $error("Registers not cleared during reset");
   chk_serial_buffer_register_kept: assert property (coreReset_q |=> $stable(serialBuf_q)) // (R7)
      else $error("Serial buffer changed by reset");
   chk_pof_kept: assert property (coreReset_q |=> $stable(powerCtrl_q[POF_BIT])) // (R8)
      else $error("Power-on flag changed by reset");
   chk_idle_gate: assert property (mode_q == PM_IDLE |-> !clocks.cpuClkEn && // (R10)
      clocks.periphClkEn && clocks.oscEn)
      else $error("Idle clock gating wrong");
   chk_idle_exit: assert property (mode_q == PM_IDLE && irqPending |=> // (R12)
      mode_q == PM_RUN && !powerCtrl_q[IDL_BIT])
      else $error("Idle not left on interrupt");
   chk_pd_stop: assert property (mode_q == PM_PDOWN |-> clocks == 3'b000) // (R13)
      else $error("Clocks running in power-down");
   chk_pd_hold: assert property (mode_q == PM_PDOWN && !extWake && !extResetPin |=> // (R14)
      mode_q == PM_PDOWN)
      else $error("Power-down left without a wake source");
   chk_pd_entry: assert property (wrHit(ADDR_POWER_CTRL) && regWdata[PD_BIT] && // (R15)
      mode_q == PM_RUN && !coreReset_q ##1 !coreReset_q |=> mode_q == PM_PDOWN)
      else $error("Power-down request bit not honoured");
   chk_ale_rate: assert property ($rose(aleOut_q) && aleAllow |-> ##6 // (R16)
      (aleOut_q || !oscRun || !$past(aleAllow)))
      else $error("Address strobe period not six clocks");
   chk_sw_entry: assert property ($rose(mode_q == PM_IDLE) |-> // (R18)
      $past(powerCtrl_q[IDL_BIT]))
      else $error("Idle entered without request bit");
   chk_warm_hold: assert property ($rose(wakeService_q) |-> // (R19)
      $past(mode_q, 2) == PM_WARM && mode_q == PM_RUN)
      else $error("Wake service before oscillator settled");

   cov_idle_wake: cover property (mode_q == PM_IDLE ##1 mode_q == PM_RUN);
   cov_pd_wake: cover property (mode_q == PM_WARM ##1 mode_q == PM_RUN);
   cov_reset: cover property ($rose(coreReset_q));

endmodule

//--- tb/mrp_wake_source.sv
`timescale 1ns/10ps
module mrp_wake_source
(
   input wire logic mclk,
   output logic extResetPin,
   output logic extIrqZero,
   output logic extIrqOne
);
   initial
   begin
      extResetPin = 1'b0;
      extIrqZero = 1'b0;
      extIrqOne = 1'b0;
   end
   task automatic pulse_reset(input int cyc);
      @(posedge mclk);
      extResetPin <= 1'b1;
      repeat (cyc) @(posedge mclk);
      extResetPin <= 1'b0;
   endtask
   task automatic set_irq(input logic z, input logic o);
      @(posedge mclk);
      extIrqZero <= z;
      extIrqOne <= o;
   endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
   import mrp_pkg::*;
   localparam int STAB = 8;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic irqPending = 1'b0;
   logic extAccess = 1'b0;
   logic optEmiLow = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic clkEn = 1'b1;
   logic [7:0] regRdata;
   mrp_ports_s portLatch;
   mrp_clk_s clocks;
   logic coreReset;
   logic aleOut;
   logic wakeService;
   logic irqOut;
   logic extResetPin;
   logic extIrqZero;
   logic extIrqOne;
   logic seenRst = 1'b0;
   int failures = 0;
   int checks_done = 0;
   int n;
   always #10 mclk = ~mclk;
   always @(posedge mclk) if (coreReset === 1'b1) seenRst <= 1'b1;
   mrp_wake_source src (.mclk(mclk), .extResetPin(extResetPin), .extIrqZero(extIrqZero),
      .extIrqOne(extIrqOne));
   mrp_reset_power #(.STAB_CYC(STAB)) DUT (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .extResetPin(extResetPin), .extIrqZero(extIrqZero), .extIrqOne(extIrqOne),
      .irqPending(irqPending), .extAccess(extAccess), .optEmiLow(optEmiLow),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .portLatch(portLatch), .clocks(clocks), .coreReset(coreReset),
      .aleOut(aleOut), .wakeService(wakeService), .irqOut(irqOut));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      check($sformatf("reg %0h", a), exp, regRdata);
   endtask
   task automatic count_ale(output int c);
      c = 0;
      repeat (6) @(posedge mclk);
      repeat (60)
      begin
         @(posedge mclk);
         #1;
         if (aleOut === 1'b1) c++;
      end
   endtask
   task automatic t_reset_vals;
      check("ports", {4{PORT_RST}}, portLatch);
      check("clocks", 3'b111, clocks);
      rdc(ADDR_STACK_PTR, STACK_PTR_RST);
      rdc(ADDR_POWER_CTRL, POWER_CTRL_POR);
      rdc(ADDR_WAKE_EN, SFR_RST);
      rdc(ADDR_IRQ_MASK, SFR_RST);
      rdc(8'h55, 8'h00);
      $display("test reset values done");
   endtask
   task automatic t_ale;
      count_ale(n);
      check("ale highs", 20, n);
      clkEn <= 1'b0;
      @(posedge mclk);
      #1;
      n = aleOut;
      repeat (10) @(posedge mclk);
      #1;
      check("ale frozen", n, aleOut);
      clkEn <= 1'b1;
      optEmiLow <= 1'b0;
      count_ale(n);
      check("ale inhibited", 0, n);
      extAccess <= 1'b1;
      count_ale(n);
      check("ale ext access", 20, n);
      extAccess <= 1'b0;
      optEmiLow <= 1'b1;
      $display("test strobe done");
   endtask
   task automatic t_idle;
      wr(ADDR_IRQ_MASK, 8'h0F);
      wr(ADDR_POWER_CTRL, 8'h11);
      @(posedge mclk);
      #1;
      check("idle clocks", 3'b011, clocks);
      repeat (2) @(posedge mclk);
      #1;
      check("idle periph", 3'b011, clocks);
      check("irq idle", 1'b1, irqOut);
      irqPending <= 1'b1;
      @(posedge mclk);
      irqPending <= 1'b0;
      #1;
      check("idle exit", 3'b111, clocks);
      rdc(ADDR_POWER_CTRL, 8'h10);
      rdc(ADDR_IRQ_STAT, 8'h01);
      rdc(ADDR_IRQ_STAT, 8'h00);
      check("irq cleared", 1'b0, irqOut);
      $display("test idle done");
   endtask
   task automatic t_pdown;
      int warm;
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_WAKE_EN, 8'h01);
      wr(ADDR_POWER_CTRL, 8'h12);
      repeat (2) @(posedge mclk);
      #1;
      check("pdown clocks", 3'b000, clocks);
      src.set_irq(1'b0, 1'b1);
      repeat (10) @(posedge mclk);
      #1;
      check("disabled wake", 3'b000, clocks);
      check("irq masked", 1'b0, irqOut);
      src.set_irq(1'b1, 1'b0);
      warm = 0;
      for (int i = 0; i < 50 && clocks !== 3'b111; i++)
      begin
         @(posedge mclk);
         #1;
         if (clocks === 3'b001) warm++;
      end
      check("warm cycles", STAB, warm);
      check("wake service", 1'b1, wakeService);
      @(posedge mclk);
      #1;
      check("wake service end", 1'b0, wakeService);
      src.set_irq(1'b0, 1'b0);
      rdc(ADDR_POWER_CTRL, 8'h10);
      wr(ADDR_IRQ_MASK, 8'h04);
      #1;
      check("irq unmasked", 1'b1, irqOut);
      rdc(ADDR_IRQ_STAT, 8'h06);
      $display("test power-down done");
   endtask
   task automatic t_ext_reset;
      wr(ADDR_PORT1, 8'h5A);
      wr(ADDR_STACK_PTR, 8'h33);
      wr(ADDR_SERIAL_BUF, 8'hA5);
      wr(ADDR_POWER_CTRL, 8'hDC);
      check("port1 written", 8'h5A, portLatch.p1);
      seenRst = 1'b0;
      src.pulse_reset(5);
      repeat (30) @(posedge mclk);
      check("glitch", 1'b0, seenRst);
      src.pulse_reset(30);
      for (int i = 0; i < 40 && coreReset !== 1'b0; i++) @(posedge mclk);
      #1;
      check("reset taken", 1'b1, seenRst);
      check("port1 reset", PORT_RST, portLatch.p1);
      rdc(ADDR_STACK_PTR, STACK_PTR_RST);
      rdc(ADDR_SERIAL_BUF, 8'hA5);
      rdc(ADDR_POWER_CTRL, 8'h10);
      check("run after reset", 3'b111, clocks);
      wr(ADDR_POWER_CTRL, 8'h00);
      rdc(ADDR_POWER_CTRL, 8'h00);
      $display("test external reset done");
   endtask
   task automatic give_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #400000;
      failures++;
      give_verdict();
   end
   initial
   begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset_vals();
      t_ale();
      t_idle();
      t_pdown();
      t_ext_reset();
      give_verdict();
   end
endmodule
